// file: fe_map.vh
// Register map, field positions, command codes and timing counts of the erase controller.
// Assumes a 40 MHz aclk; included by the controller module by bare name.
// Overview of operation
// - Extra sectors added within 50 us each
// - Hardware reset aborts erase; reissue sequence
// - Sector erase: six cycles, sector with 30
// - Chip erase: five setup, then 555/10
// - Suspend only during sector erase, with address
// - Resume at suspended sector; repeats ignored
// - Suspend is one write of B0
// - Resume is one write of 30 to sector
`ifndef FE_MAP_VH
`define FE_MAP_VH
// Register byte offsets
`define FE_REG_CTRL      4'h0
`define FE_REG_ADDR      4'h4
`define FE_REG_STAT      4'h8
`define FE_REG_RDAT      4'hc
// Control fields
`define FE_CTRL_CMD_LSB  0
`define FE_CTRL_GO       3
`define FE_CTRL_BYTE     4
// Status fields
`define FE_STAT_BUSY     0
`define FE_STAT_REFUSED  1
`define FE_STAT_TIMER    2
`define FE_STAT_REISSUE  3
`define FE_STAT_PH_LSB   4
`define FE_STAT_DONE     9
// Command codes
`define FE_CMD_SECTOR    3'h0
`define FE_CMD_CHIP      3'h1
`define FE_CMD_ADD       3'h2
`define FE_CMD_SUSPEND   3'h3
`define FE_CMD_RESUME    3'h4
`define FE_CMD_READ      3'h5
`define FE_CMD_HWRST     3'h6
`define FE_CMD_POLL      3'h7
// Flash command words and unlock addresses
`define FE_D_UNLOCK1     16'h00aa
`define FE_D_UNLOCK2     16'h0055
`define FE_D_SETUP       16'h0080
`define FE_D_SECTOR      16'h0030
`define FE_D_CHIP        16'h0010
`define FE_D_SUSPEND     16'h00b0
`define FE_D_RESUME      16'h0030
`define FE_A_W_UNLOCK1   12'h555
`define FE_A_W_UNLOCK2   12'h2aa
`define FE_A_B_UNLOCK1   12'haaa
`define FE_A_B_UNLOCK2   12'h555
// Status bit positions in a read word
`define FE_BIT_TIMER     3
`define FE_BIT_TOGGLE    6
// Timing in ns and derived cycle counts at 25 ns
`define FE_CLK_NS        25
`define FE_WIN_NS        50000
`define FE_WIN_CYC       (`FE_WIN_NS / `FE_CLK_NS)
`define FE_WP_NS         35
`define FE_WP_CYC        ((`FE_WP_NS + `FE_CLK_NS - 1) / `FE_CLK_NS)
`define FE_WPH_NS        30
`define FE_WPH_CYC       ((`FE_WPH_NS + `FE_CLK_NS - 1) / `FE_CLK_NS)
`define FE_ACC_NS        110
`define FE_ACC_CYC       ((`FE_ACC_NS + `FE_CLK_NS - 1) / `FE_CLK_NS)
`define FE_RP_NS         500
`define FE_RP_CYC        ((`FE_RP_NS + `FE_CLK_NS - 1) / `FE_CLK_NS)
`define FE_RH_NS         50000
`define FE_RH_CYC        (`FE_RH_NS / `FE_CLK_NS)
// Erase phase codes as tracked by the host
`define FE_PH_IDLE       3'h0
`define FE_PH_WINDOW     3'h1
`define FE_PH_SECTOR     3'h2
`define FE_PH_CHIP       3'h3
`define FE_PH_SUSP       3'h4
`endif

// file: fe_ctrl.v
// Host-side erase controller: AXI4-Lite registers in, parallel NOR flash pins out.
// Assumes one 40 MHz clock; flash data pins come in asynchronously through a 3-stage synchroniser.
//
// The register addresses and the AXI4-Lite slave port were decided locally.
`include "fe_map.vh"

module fe_ctrl #(
    parameter AW     = 24,          // Flash word address width
    parameter WIN    = `FE_WIN_CYC, // Sector add window in cycles
    parameter RH     = `FE_RH_CYC   // Wait after hardware reset in cycles
) (
    // Clock and reset
    input  wire          aclk,
    input  wire          aresetn,
    // AXI4-Lite write address and data
    input  wire [3:0]    s_axi_awaddr,
    input  wire          s_axi_awvalid,
    output wire          s_axi_awready,
    input  wire [31:0]   s_axi_wdata,
    input  wire [3:0]    s_axi_wstrb,
    input  wire          s_axi_wvalid,
    output wire          s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]    s_axi_bresp,
    output reg           s_axi_bvalid,
    input  wire          s_axi_bready,
    // AXI4-Lite read
    input  wire [3:0]    s_axi_araddr,
    input  wire          s_axi_arvalid,
    output wire          s_axi_arready,
    output reg  [31:0]   s_axi_rdata,
    output reg  [1:0]    s_axi_rresp,
    output reg           s_axi_rvalid,
    input  wire          s_axi_rready,
    // Flash pins
    output reg  [AW-1:0] fl_addr,
    output reg  [15:0]   fl_dq_o,
    input  wire [15:0]   fl_dq_i,
    output reg           fl_dq_oe_n,
    output reg           fl_ce_n,
    output reg           fl_we_n,
    output reg           fl_oe_n,
    output reg           fl_reset_n
);

    // Bus sequencer states, one-hot
    localparam S_IDLE  = 6'b000001;
    localparam S_SETUP = 6'b000010;
    localparam S_WEL   = 6'b000100;
    localparam S_WEH   = 6'b001000;
    localparam S_OEL   = 6'b010000;
    localparam S_RST   = 6'b100000;

    reg  [5:0]    st_q;          // Sequencer state
    reg  [2:0]    cmd_q;         // Command being run
    reg  [2:0]    step_q;        // Write step within a sequence
    reg  [15:0]   cnt_q;         // Phase cycle counter
    reg  [15:0]   win_q;         // Cycles since last final erase strobe
    reg  [2:0]    ph_q;          // Host view of device erase phase
    reg  [AW-1:0] sec_q;         // Sector address register
    reg  [AW-1:0] susp_sec_q;    // Sector that was suspended
    reg           byte_q;        // Byte-mode unlock addresses
    reg           refused_q;     // Sticky: a command was refused
    reg           done_q;        // Sticky: a command finished
    reg           reissue_q;     // Erase cut short by hardware reset
    reg           timer_q;       // Last erase timer flag seen
    reg  [15:0]   rdat_q;        // Last word read from the flash
    reg           poll_first_q;  // Poll has one sample already
    reg  [15:0]   s1_q, s2_q, s3_q; // Data pin synchroniser
    reg           aw_q, w_q;     // Write address / data held
    reg  [3:0]    awaddr_q;
    reg  [31:0]   wdata_q;

    // Address of each write step; suspend address is not decoded but sector is sent anyway
    function [AW-1:0] step_addr;
        input [2:0]    step;
        input [2:0]    cmd;
        input          bmode;
        input [AW-1:0] sec;
        input [AW-1:0] ssec;
        begin
            case (step)
                3'd1, 3'd4: step_addr = bmode ? {{(AW-12){1'b0}}, `FE_A_B_UNLOCK2} : {{(AW-12){1'b0}}, `FE_A_W_UNLOCK2};
                3'd5: begin
                    if (cmd == `FE_CMD_CHIP)
                        step_addr = bmode ? {{(AW-12){1'b0}}, `FE_A_B_UNLOCK1} : {{(AW-12){1'b0}}, `FE_A_W_UNLOCK1};
                    else if (cmd == `FE_CMD_RESUME)
                        step_addr = ssec;
                    else
                        step_addr = sec;
                end
                default: step_addr = bmode ? {{(AW-12){1'b0}}, `FE_A_B_UNLOCK1} : {{(AW-12){1'b0}}, `FE_A_W_UNLOCK1};
            endcase
        end
    endfunction

    // Data of each write step
    function [15:0] step_data;
        input [2:0] step;
        input [2:0] cmd;
        begin
            case (step)
                3'd0, 3'd3: step_data = `FE_D_UNLOCK1;
                3'd1, 3'd4: step_data = `FE_D_UNLOCK2;
                3'd2:       step_data = `FE_D_SETUP;
                default: begin
                    case (cmd)
                        `FE_CMD_CHIP:    step_data = `FE_D_CHIP;
                        `FE_CMD_SUSPEND: step_data = `FE_D_SUSPEND;
                        `FE_CMD_RESUME:  step_data = `FE_D_RESUME;
                        default:         step_data = `FE_D_SECTOR;
                    endcase
                end
            endcase
        end
    endfunction

    // Register decode of a write to the control word
    wire        wr_fire  = aw_q & w_q & ~s_axi_bvalid;
    reg         wstrb0_q;
    wire        ctrl_wr  = wr_fire & (awaddr_q == `FE_REG_CTRL) & wstrb0_q;
    wire        go       = ctrl_wr & wdata_q[`FE_CTRL_GO];
    wire [2:0]  go_cmd   = wdata_q[`FE_CTRL_CMD_LSB+2:`FE_CTRL_CMD_LSB];
    wire        win_open = (win_q < WIN[15:0]);
    reg         allow;

    // Decide whether a command fits the present erase phase
    always @* begin
        case (go_cmd)
            `FE_CMD_SECTOR, `FE_CMD_CHIP: allow = (ph_q == `FE_PH_IDLE) || (ph_q == `FE_PH_SUSP && 1'b0);
            `FE_CMD_ADD:     allow = (ph_q == `FE_PH_WINDOW) && win_open;
            `FE_CMD_SUSPEND: allow = (ph_q == `FE_PH_WINDOW) || (ph_q == `FE_PH_SECTOR);
            `FE_CMD_RESUME:  allow = (ph_q == `FE_PH_SUSP);
            `FE_CMD_READ, `FE_CMD_POLL, `FE_CMD_HWRST: allow = 1'b1;
            default:         allow = 1'b0;
        endcase
        // Only suspend, add, read, poll and reset may reach a busy sector erase; only read, poll and reset a chip erase
        if ((ph_q == `FE_PH_SECTOR || ph_q == `FE_PH_WINDOW) && go_cmd != `FE_CMD_SUSPEND && go_cmd != `FE_CMD_ADD
            && go_cmd != `FE_CMD_READ && go_cmd != `FE_CMD_POLL && go_cmd != `FE_CMD_HWRST)
            allow = 1'b0;
        if (ph_q == `FE_PH_CHIP && go_cmd != `FE_CMD_READ && go_cmd != `FE_CMD_POLL && go_cmd != `FE_CMD_HWRST)
            allow = 1'b0;
        if (st_q != S_IDLE)
            allow = 1'b0;
    end

    assign s_axi_awready = ~aw_q;
    assign s_axi_wready  = ~w_q;
    assign s_axi_arready = ~s_axi_rvalid;

    // Data pins pass three flops; a value counts once stages two and three agree
    always @(posedge aclk) begin
        if (!aresetn) begin
            s1_q <= 16'h0000;
            s2_q <= 16'h0000;
            s3_q <= 16'h0000;
        end else begin
            s1_q <= fl_dq_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // AXI write side: hold address and data until both are in, then answer
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_q           <= 1'b0;
            w_q            <= 1'b0;
            awaddr_q       <= 4'h0;
            wdata_q        <= 32'h00000000;
            wstrb0_q       <= 1'b0;
            s_axi_bvalid   <= 1'b0;
            s_axi_bresp    <= 2'b00;
        end else begin
            if (s_axi_awvalid && !aw_q) begin
                aw_q     <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_q) begin
                w_q            <= 1'b1;
                wdata_q        <= s_axi_wdata;
                wstrb0_q       <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                // Offsets not on a word boundary answer with a slave error
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awaddr_q[1:0] != 2'b00) ? 2'b10 : 2'b00;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_q         <= 1'b0;
                w_q          <= 1'b0;
            end
        end
    end

    // AXI read side: answer one cycle after the address is taken
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= 2'b00;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= (s_axi_araddr[1:0] != 2'b00) ? 2'b10 : 2'b00;
            case (s_axi_araddr)
                `FE_REG_CTRL: s_axi_rdata <= {27'h0, byte_q, 1'b0, cmd_q};
                `FE_REG_ADDR: s_axi_rdata <= {{(32-AW){1'b0}}, sec_q};
                `FE_REG_STAT: s_axi_rdata <= {22'h0, done_q, 2'b00, ph_q, reissue_q, timer_q,
                                              refused_q, (st_q != S_IDLE)};
                `FE_REG_RDAT: s_axi_rdata <= {16'h0, rdat_q};
                default:      s_axi_rdata <= 32'h00000000;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Flash bus sequencer, erase phase tracking and software-visible flags
    always @(posedge aclk) begin
        if (!aresetn) begin
            st_q         <= S_IDLE;
            cmd_q        <= 3'h0;
            step_q       <= 3'd0;
            cnt_q        <= 16'h0000;
            win_q        <= 16'h0000;
            ph_q         <= `FE_PH_IDLE;
            sec_q        <= {AW{1'b0}};
            susp_sec_q   <= {AW{1'b0}};
            byte_q       <= 1'b0;
            refused_q    <= 1'b0;
            done_q       <= 1'b0;
            reissue_q    <= 1'b0;
            timer_q      <= 1'b0;
            rdat_q       <= 16'h0000;
            poll_first_q <= 1'b0;
            fl_addr      <= {AW{1'b0}};
            fl_dq_o      <= 16'h0000;
            fl_dq_oe_n   <= 1'b1;
            fl_ce_n      <= 1'b1;
            fl_we_n      <= 1'b1;
            fl_oe_n      <= 1'b1;
            fl_reset_n   <= 1'b1;
        end else begin
            // Software clears sticky flags by writing ones to the status word; a set this cycle wins
            if (wr_fire && awaddr_q == `FE_REG_STAT) begin
                if (wdata_q[`FE_STAT_REFUSED]) refused_q <= 1'b0;
                if (wdata_q[`FE_STAT_DONE])    done_q    <= 1'b0;
                if (wdata_q[`FE_STAT_REISSUE]) reissue_q <= 1'b0;
            end
            if (wr_fire && awaddr_q == `FE_REG_ADDR)
                sec_q <= wdata_q[AW-1:0];
            // Device starts erasing once the window lapses, counted from the final strobe
            if (ph_q == `FE_PH_WINDOW) begin
                if (win_open)
                    win_q <= win_q + 16'h0001;
                else
                    ph_q <= `FE_PH_SECTOR;
            end
            if (ctrl_wr) begin
                byte_q <= wdata_q[`FE_CTRL_BYTE];
                if (go && !allow)
                    refused_q <= 1'b1;
            end
            case (st_q)
                S_IDLE: begin
                    if (go && allow) begin
                        cmd_q  <= go_cmd;
                        cnt_q  <= 16'h0000;
                        // Single-write commands start at the final step
                        step_q <= (go_cmd == `FE_CMD_SECTOR || go_cmd == `FE_CMD_CHIP) ? 3'd0 : 3'd5;
                        poll_first_q <= 1'b0;
                        if (go_cmd == `FE_CMD_HWRST) begin
                            fl_reset_n <= 1'b0;
                            st_q       <= S_RST;
                        end else begin
                            st_q <= S_SETUP;
                        end
                    end
                end
                S_SETUP: begin
                    // Address and chip select go out on the same edge as the falling strobe
                    fl_ce_n <= 1'b0;
                    cnt_q   <= 16'h0000;
                    if (cmd_q == `FE_CMD_READ || cmd_q == `FE_CMD_POLL) begin
                        fl_addr    <= sec_q;
                        fl_dq_oe_n <= 1'b1;
                        fl_oe_n    <= 1'b0;
                        st_q       <= S_OEL;
                    end else begin
                        fl_addr    <= step_addr(step_q, cmd_q, byte_q, sec_q, susp_sec_q);
                        fl_dq_o    <= step_data(step_q, cmd_q);
                        fl_dq_oe_n <= 1'b0;
                        fl_we_n    <= 1'b0;
                        st_q       <= S_WEL;
                    end
                end
                S_WEL: begin
                    cnt_q <= cnt_q + 16'h0001;
                    if (cnt_q + 16'h0001 >= `FE_WP_CYC) begin
                        fl_we_n <= 1'b1;
                        cnt_q   <= 16'h0000;
                        st_q    <= S_WEH;
                        if (step_q == 3'd5) begin
                            // Final strobe rising edge: update the host view of the device
                            case (cmd_q)
                                `FE_CMD_SECTOR, `FE_CMD_ADD: begin
                                    ph_q  <= `FE_PH_WINDOW;
                                    win_q <= 16'h0000;
                                end
                                `FE_CMD_CHIP:    ph_q <= `FE_PH_CHIP;
                                `FE_CMD_SUSPEND: begin
                                    ph_q       <= `FE_PH_SUSP;
                                    susp_sec_q <= sec_q;
                                end
                                `FE_CMD_RESUME:  ph_q <= `FE_PH_SECTOR;
                                default:         ph_q <= ph_q;
                            endcase
                        end
                    end
                end
                S_WEH: begin
                    // Write pulse high time before the next cycle
                    cnt_q <= cnt_q + 16'h0001;
                    if (cnt_q + 16'h0001 >= `FE_WPH_CYC) begin
                        fl_dq_oe_n <= 1'b1;
                        if (step_q == 3'd5) begin
                            fl_ce_n <= 1'b1;
                            done_q  <= 1'b1;
                            st_q    <= S_IDLE;
                        end else begin
                            step_q <= step_q + 3'd1;
                            st_q   <= S_SETUP;
                        end
                    end
                end
                S_OEL: begin
                    // Wait out access time plus the synchroniser before trusting the word
                    cnt_q <= cnt_q + 16'h0001;
                    if (cnt_q >= `FE_ACC_CYC + 3 && s2_q == s3_q) begin
                        rdat_q  <= s3_q;
                        timer_q <= s3_q[`FE_BIT_TIMER];
                        fl_oe_n <= 1'b1;
                        fl_ce_n <= 1'b1;
                        if (cmd_q == `FE_CMD_POLL && !poll_first_q) begin
                            poll_first_q <= 1'b1;
                            st_q         <= S_SETUP;
                        end else if (cmd_q == `FE_CMD_POLL && rdat_q[`FE_BIT_TOGGLE] != s3_q[`FE_BIT_TOGGLE]) begin
                            // Toggle still moving: the device is busy, read again
                            st_q <= S_SETUP;
                        end else begin
                            // Toggle stopped: an erase has ended and the sector reads array data
                            if (cmd_q == `FE_CMD_POLL && (ph_q == `FE_PH_SECTOR || ph_q == `FE_PH_CHIP))
                                ph_q <= `FE_PH_IDLE;
                            done_q <= 1'b1;
                            st_q   <= S_IDLE;
                        end
                    end
                end
                S_RST: begin
                    // Reset pulse, then a wait before the device is used again
                    cnt_q <= cnt_q + 16'h0001;
                    if (cnt_q + 16'h0001 >= `FE_RP_CYC)
                        fl_reset_n <= 1'b1;
                    if (cnt_q + 16'h0001 >= `FE_RP_CYC + RH) begin
                        if (ph_q != `FE_PH_IDLE)
                            reissue_q <= 1'b1;
                        ph_q   <= `FE_PH_IDLE;
                        done_q <= 1'b1;
                        st_q   <= S_IDLE;
                    end
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

endmodule // fe_ctrl

// file: fe_ctrl_checker.sv
// Checks on the controller's flash strobes and command words.
// Bound to fe_ctrl from the bench; sees its ports only.
module fe_ctrl_checker #(parameter AW = 24) (
    input wire logic          aclk, aresetn,
    input wire logic [AW-1:0] fl_addr,
    input wire logic [15:0]   fl_dq_o,
    input wire logic          fl_dq_oe_n, fl_ce_n, fl_we_n, fl_reset_n
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Strobe low two cycles, then high at least two
    AST_WE_WIDTH: assert property ($fell(fl_we_n) |=> !fl_we_n ##1 fl_we_n [*2])
        else $error("strobe width");
    // Word and address launch with the falling strobe, then must not move while it stays low
    AST_WE_HOLD: assert property (!fl_we_n |-> !fl_ce_n && !fl_dq_oe_n
        && ($fell(fl_we_n) || $stable(fl_dq_o) && $stable(fl_addr)))
        else $error("write not held");
    AST_UNLOCK1: assert property ($fell(fl_we_n) && fl_dq_o inside {16'h00aa, 16'h0080}
        |-> fl_addr[11:0] inside {12'h555, 12'haaa}) else $error("unlock1 address");
    AST_UNLOCK2: assert property ($fell(fl_we_n) && fl_dq_o == 16'h0055
        |-> fl_addr[11:0] inside {12'h2aa, 12'h555}) else $error("unlock2 address");
    AST_CHIP_ADDR: assert property ($fell(fl_we_n) && fl_dq_o == 16'h0010
        |-> fl_addr[11:0] inside {12'h555, 12'haaa}) else $error("chip address");
    // Setup word is followed by the second unlock pair at once
    AST_SETUP_NEXT: assert property ($fell(fl_we_n) && fl_dq_o == 16'h0080
        |-> ##5 $fell(fl_we_n) && fl_dq_o == 16'h00aa) else $error("setup order");
    AST_RST_PULSE: assert property ($fell(fl_reset_n) |-> (!fl_reset_n && fl_we_n) [*8])
        else $error("reset pulse");
    // Suspend is a single write with nothing behind it
    AST_SUSP_ALONE: assert property ($fell(fl_we_n) && fl_dq_o == 16'h00b0 |-> ##2 fl_we_n [*8])
        else $error("suspend not alone");
endmodule // fe_ctrl_checker

// file: fe_flash_model.sv
// Behavioural flash: decodes erase sequences, times window and erase, answers reads.
// Word mode only; sector is address bits 23:16; times in ns.
module fe_flash_model #(parameter int WIN_NS = 1250, parameter int ERASE_NS = 10000) (
    input  wire logic [23:0] fl_addr,
    input  wire logic [15:0] fl_dq_o,
    input  wire logic        fl_dq_oe_n, fl_ce_n, fl_we_n, fl_oe_n, fl_reset_n,
    output wire logic [15:0] fl_dq_i
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [255:0] sel = '0, erased = '0; // Queued and erased sectors
    logic [15:0]  ud [5] = '{16'haa, 16'h55, 16'h80, 16'haa, 16'h55};
    logic [11:0]  ua [5] = '{12'h555, 12'h2aa, 12'h555, 12'h555, 12'h2aa};
    int           st = 0, left = 0; // 0-5 setup, 6 window, 7 sector, 8 chip, 9 suspended
    realtime      t0 = 0;
    logic         tog = 0; // Flips on every read
    wire [7:0]    s = fl_addr[23:16];
    wire [15:0]   rd = (st > 5 && (sel[s] || st == 8)) ? {8'h0, st == 9, tog && st != 9, 2'b0, st != 6, tog, 2'b0}
                     : {16{erased[s]}};
    assign fl_dq_i = (!fl_ce_n && !fl_oe_n && fl_dq_oe_n) ? rd : ~rd; // Released bus never keeps the last word
    // Commands act on the rising strobe; busy erases drop all else
    always @(posedge fl_we_n) if (!fl_ce_n && fl_reset_n) begin
        if (st < 5) begin
            st = (fl_addr[11:0] == ua[st] && fl_dq_o == ud[st]) ? st + 1 : 0;
            left = ERASE_NS;
        end
        else if (fl_dq_o == 16'h30 && (st == 5 || (st == 6 && $realtime - t0 < WIN_NS))) begin
            sel[s] = 1;
            st = 6;
            t0 = $realtime;
        end
        else if (st == 5) st = (fl_dq_o == 16'h10 && fl_addr[11:0] == 12'h555) ? 8 : 0;
        else if ((st == 6 || st == 7) && fl_dq_o == 16'hb0) st = 9;
        else if (st == 6) st = 0;
        else if (st == 9 && fl_dq_o == 16'h30 && sel[s]) st = 7;
    end
    // Window expiry, then erase time that stands still while suspended
    always #25 begin
        if (st == 6 && $realtime - t0 >= WIN_NS) st = 7;
        if (st == 7 || st == 8) left -= 25;
        if ((st == 7 || st == 8) && left <= 0) begin
            erased |= (st == 8) ? '1 : sel;
            st = 0;
        end
        if (st == 0) sel = '0;
    end
    always @(negedge fl_oe_n) tog = ~tog;
    always @(negedge fl_reset_n) st = 0;
endmodule // fe_flash_model

// file: fe_ctrl_tb.sv
// Self-checking bench: AXI4-Lite tasks drive the erase controller against the flash model.
// Window and post-reset wait shortened to 50 cycles of the 40 MHz clock.
`include "fe_map.vh"
module fe_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic        s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [3:0]  s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = '0, d;
    logic [1:0]  r;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire  [23:0] fl_addr;
    wire  [15:0] fl_dq_o, fl_dq_i;
    wire         fl_dq_oe_n, fl_ce_n, fl_we_n, fl_oe_n, fl_reset_n;
    int          mismatches = 0, n_compared = 0, cyc = 0;
    fe_ctrl #(.WIN(50), .RH(50)) i_fe_ctrl (.*);
    fe_flash_model i_fe_flash_model (.*);
    always #12.5 aclk = ~aclk;
    // Hang guard: a run needs well under this many cycles
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            give_verdict();
        end
    end
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 0;
        chk({14'h0, s_axi_bresp}, (a[1:0] != 2'b00) ? 16'h0002 : 16'h0000, "bresp");
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        v = s_axi_rdata;
        e = s_axi_rresp;
        s_axi_rready <= 0;
    endtask
    task automatic chk(input logic [15:0] g, e, input string m);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] t=%0t %s got %h want %h", $time, m, g, e);
        end
    endtask
    // Issue one command and wait until busy drops; leaves status in d
    task automatic op(input logic [2:0] c, input logic [23:0] a);
        wr(`FE_REG_ADDR, {8'h0, a});
        wr(`FE_REG_CTRL, {28'h0, 1'b1, c});
        do rd(`FE_REG_STAT, d, r); while (d[0] !== 1'b0);
    endtask
    task automatic arr(input logic [23:0] a, input logic [15:0] e, input string m);
        op(`FE_CMD_READ, a);
        rd(`FE_REG_RDAT, d, r);
        chk(d[15:0] & ((a == 24'h030000) ? 16'h0080 : 16'hffff), e, m);
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        op(`FE_CMD_SECTOR, 24'h010000);
        chk(d[15:0] & 16'h0072, 16'h0010, "window");
        op(`FE_CMD_ADD, 24'h020000);
        chk(d[15:0] & 16'h0072, 16'h0010, "add");
        wr(`FE_REG_STAT, 32'h200);
        op(`FE_CMD_POLL, 24'h010000);
        chk(d[15:0] & 16'h0272, 16'h0200, "done");
        arr(24'h040000, 16'h0000, "untouched");
        arr(24'h010000, 16'hffff, "sector one");
        arr(24'h020000, 16'hffff, "queued");
        $display("test sector erase ended");
        op(`FE_CMD_SECTOR, 24'h030000);
        op(`FE_CMD_READ, 24'h030000);
        chk(d[15:0] & 16'h0004, 16'h0000, "timer open");
        op(`FE_CMD_SUSPEND, 24'h030000);
        chk(d[15:0] & 16'h0072, 16'h0040, "suspend");
        arr(24'h030000, 16'h0080, "suspend status");
        op(`FE_CMD_RESUME, 24'h030000);
        chk(d[15:0] & 16'h0072, 16'h0020, "resume");
        op(`FE_CMD_RESUME, 24'h030000);
        chk(d[15:0] & 16'h0072, 16'h0022, "resume again");
        wr(`FE_REG_STAT, 32'h2);
        op(`FE_CMD_POLL, 24'h030000);
        arr(24'h050000, 16'h0000, "other sector");
        $display("test suspend ended");
        op(`FE_CMD_SECTOR, 24'h060000);
        repeat (60) @(posedge aclk);
        op(`FE_CMD_READ, 24'h060000);
        chk(d[15:0] & 16'h0004, 16'h0004, "timer run");
        op(`FE_CMD_HWRST, 24'h0);
        chk(d[15:0] & 16'h0008, 16'h0008, "reissue");
        arr(24'h060000, 16'h0000, "aborted");
        op(`FE_CMD_SECTOR, 24'h060000);
        op(`FE_CMD_POLL, 24'h060000);
        arr(24'h060000, 16'hffff, "reissued");
        $display("test hardware reset ended");
        op(`FE_CMD_CHIP, 24'h0);
        chk(d[15:0] & 16'h0072, 16'h0030, "chip");
        op(`FE_CMD_SUSPEND, 24'h0);
        chk(d[15:0] & 16'h0072, 16'h0032, "chip suspend");
        wr(`FE_REG_STAT, 32'h2);
        op(`FE_CMD_POLL, 24'h0);
        arr(24'h050000, 16'hffff, "chip erased");
        wr(4'h2, 32'h0);
        rd(4'h1, d, r);
        chk({14'h0, r}, 16'h0002, "misaligned");
        $display("test chip erase ended");
        give_verdict();
    end
endmodule // fe_ctrl_tb
bind fe_ctrl fe_ctrl_checker #(.AW(AW)) i_fe_ctrl_checker (.*);
